//--- design/gpc_handler.sv
/*
  global parameter command handler: takes nine-byte command frames,
  keeps module settings, user variables and interrupt settings in
  flip-flops, and answers with nine-byte reply frames.
  assumes an external non-volatile store that answers each request
  with a one-cycle nvm_ack, and byte streams synchronous to clk.
*/
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// R1 - bank field picks the group: 0 module settings, 2 user variables, 3 interrupts
// R2 - every bank 0 write is also written to non-volatile memory automatically
// R3 - set-global (9) writes the 32-bit value to the selected parameter, replies 100
// R4 - get-global (10) reads selected parameter; request value field is ignored
// R5 - direct-mode get-global reply carries status 100 and the value read
// R6 - store (11, bank 2) writes user variable to non-volatile memory, replies 100
// R7 - at power-up user variables reload from non-volatile copies unless disabled
// R8 - restore (12, bank 2) overwrites user variable from non-volatile memory, replies 100
// R9 - parameter 66 of bank 0 is the serial bus address, settable and readable
// R10 - host uses store mainly for bank 2 since bank 0 saves itself
// R11 - direct-mode reads leave accumulator alone; standalone reads load it
// R12 - frames are nine bytes, value msb first, checksum is sum of first eight
module gpc_handler
  import gpc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic standalone_mode,
  input wire logic auto_restore_en,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  output logic rx_ready,
  output logic tx_valid,
  output logic [7:0] tx_byte,
  input wire logic tx_ready,
  output logic nvm_req,
  output logic nvm_we,
  output logic [9:0] nvm_addr,
  output logic [31:0] nvm_wdata,
  input wire logic [31:0] nvm_rdata,
  input wire logic nvm_ack,
  output logic [31:0] accumulator,
  output logic [7:0] serial_addr
);
  // -----------------------------------------------------------------
  // reset release
  // -----------------------------------------------------------------
  logic rst_meta_reg, rst_n;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  gpc_state_t state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] frm_reg [8], frm_next [8];
  logic [7:0] sum_reg, sum_next;
  logic [7:0] tx_reg [FRAME_LEN], tx_next [FRAME_LEN];
  logic [31:0] acc_reg, acc_next;
  logic nvm_we_reg, nvm_we_next;
  logic [9:0] nvm_addr_reg, nvm_addr_next;
  logic [31:0] nvm_wdata_reg, nvm_wdata_next;
  logic [5:0] boot_idx_reg, boot_idx_next;
  logic [7:0] idx_reg, idx_next;
  logic [31:0] store_reg [STORE_WORDS];
  logic wr_en;
  logic [7:0] wr_idx;
  logic [31:0] wr_data;
  logic ex_ok;
  logic [7:0] ex_idx;
  logic [31:0] ex_val, rd_val;

  // frame fields of the frame under execution
  wire logic [7:0] f_instr = frm_reg[F_INSTR];
  wire logic [7:0] f_type = frm_reg[F_TYPE];
  wire logic [7:0] f_bank = frm_reg[F_BANK];
  assign ex_val = {frm_reg[F_VAL3], frm_reg[F_VAL3 + 1], frm_reg[F_VAL3 + 2], frm_reg[F_VAL3 + 3]}; // R12

  // bank select into the flat store; only banks 0, 2 and 3 exist
  always_comb begin
    ex_ok = 1'b0;
    ex_idx = 8'h00;
    if (f_bank == BANK_MODULE && f_type < MOD_DEPTH) begin // R1
      ex_ok = 1'b1;
      ex_idx = f_type;
    end else if (f_bank == BANK_UVAR && f_type < UVAR_DEPTH) begin // R1
      ex_ok = 1'b1;
      ex_idx = UVAR_BASE + f_type;
    end else if (f_bank == BANK_IRQ && f_type < IRQ_DEPTH) begin // R1
      ex_ok = 1'b1;
      ex_idx = IRQ_BASE + f_type;
    end
  end
  assign rd_val = store_reg[ex_idx];

  // reply frame: host, module, status, instruction, value, checksum
  function automatic void put_reply(input logic [7:0] st, input logic [7:0] ins,
                                    input logic [31:0] v, input logic [7:0] me,
                                    output logic [7:0] r [FRAME_LEN]);
    logic [7:0] s;
    r[0] = HOST_ADDR;
    r[1] = me;
    r[2] = st;
    r[3] = ins;
    r[4] = v[31:24];
    r[5] = v[23:16];
    r[6] = v[15:8];
    r[7] = v[7:0];
    s = 8'h00;
    for (int i = 0; i < 8; i++) begin
      s = s + r[i]; // R12
    end
    r[8] = s;
  endfunction

  // -----------------------------------------------------------------
  // next-state logic
  // -----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    frm_next = frm_reg;
    sum_next = sum_reg;
    tx_next = tx_reg;
    acc_next = acc_reg;
    nvm_we_next = nvm_we_reg;
    nvm_addr_next = nvm_addr_reg;
    nvm_wdata_next = nvm_wdata_reg;
    boot_idx_next = boot_idx_reg;
    idx_next = idx_reg;
    wr_en = 1'b0;
    wr_idx = 8'h00;
    wr_data = 32'h0000_0000;
    unique case (state_reg)
      // strap is caught here, one cycle after reset release
      S_INIT: begin
        boot_idx_next = 6'h00;
        nvm_we_next = 1'b0;
        nvm_addr_next = {BANK_UVAR[1:0], 8'h00};
        state_next = auto_restore_en ? S_BOOT : S_RX; // R7
      end
      S_BOOT: begin
        if (nvm_ack) begin
          wr_en = 1'b1; // R7
          wr_idx = UVAR_BASE + {2'b00, boot_idx_reg};
          wr_data = nvm_rdata;
          boot_idx_next = boot_idx_reg + 6'h01;
          nvm_addr_next = {BANK_UVAR[1:0], 2'b00, boot_idx_reg + 6'h01};
          if (boot_idx_reg == UVAR_LAST) begin
            state_next = S_RX;
          end
        end
      end
      S_RX: begin
        if (rx_valid) begin
          if (cnt_reg == LAST_BYTE) begin
            cnt_next = FIRST_BYTE;
            sum_next = 8'h00;
            if (frm_reg[F_ADDR] == serial_addr) begin
              if (sum_reg == rx_byte) begin // R12
                state_next = S_EXEC;
              end else begin
                put_reply(STAT_BAD_CSUM, frm_reg[F_INSTR], 32'h0000_0000, serial_addr, tx_next);
                state_next = S_TX;
              end
            end
          end else begin
            frm_next[cnt_reg[2:0]] = rx_byte;
            sum_next = sum_reg + rx_byte;
            cnt_next = cnt_reg + 4'h1;
          end
        end
      end
      S_EXEC: begin
        idx_next = ex_idx;
        state_next = S_TX;
        if (!ex_ok) begin
          put_reply(STAT_BAD_TYPE, f_instr, 32'h0000_0000, serial_addr, tx_next); // R1
        end else if (f_instr == set_global_param_cmd) begin
          wr_en = 1'b1; // R3
          wr_idx = ex_idx;
          wr_data = ex_val;
          put_reply(STAT_OK, f_instr, 32'h0000_0000, serial_addr, tx_next); // R3
          if (f_bank == BANK_MODULE) begin
            nvm_we_next = 1'b1; // R2
            nvm_addr_next = {f_bank[1:0], f_type};
            nvm_wdata_next = ex_val;
            state_next = S_NVM;
          end
        end else if (f_instr == get_global_param_cmd) begin
          put_reply(STAT_OK, f_instr, rd_val, serial_addr, tx_next); // R4 R5 R9
          if (standalone_mode) begin
            acc_next = rd_val; // R11
          end
        end else if ((f_instr == store_user_var_cmd || f_instr == restore_user_var_cmd)
                     && f_bank == BANK_UVAR) begin
          nvm_we_next = (f_instr == store_user_var_cmd); // R6 R8
          nvm_addr_next = {f_bank[1:0], f_type};
          nvm_wdata_next = rd_val;
          put_reply(STAT_OK, f_instr, 32'h0000_0000, serial_addr, tx_next); // R6 R8
          state_next = S_NVM;
        end else begin
          put_reply(STAT_BAD_CMD, f_instr, 32'h0000_0000, serial_addr, tx_next);
        end
      end
      // hold the request until the store answers; reply is already built
      S_NVM: begin
        if (nvm_ack) begin
          state_next = S_TX;
          if (!nvm_we_reg) begin
            wr_en = 1'b1; // R8
            wr_idx = idx_reg;
            wr_data = nvm_rdata;
          end
        end
      end
      S_TX: begin
        if (tx_ready) begin
          if (cnt_reg == LAST_BYTE) begin
            cnt_next = FIRST_BYTE;
            state_next = S_RX;
          end else begin
            cnt_next = cnt_reg + 4'h1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= S_INIT;
      cnt_reg <= FIRST_BYTE;
      frm_reg <= '{default: 8'h00};
      sum_reg <= 8'h00;
      tx_reg <= '{default: 8'h00};
      acc_reg <= 32'h0000_0000;
      nvm_we_reg <= 1'b0;
      nvm_addr_reg <= 10'h000;
      nvm_wdata_reg <= 32'h0000_0000;
      boot_idx_reg <= 6'h00;
      idx_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      frm_reg <= frm_next;
      sum_reg <= sum_next;
      tx_reg <= tx_next;
      acc_reg <= acc_next;
      nvm_we_reg <= nvm_we_next;
      nvm_addr_reg <= nvm_addr_next;
      nvm_wdata_reg <= nvm_wdata_next;
      boot_idx_reg <= boot_idx_next;
      idx_reg <= idx_next;
    end
  end

  // -----------------------------------------------------------------
  // parameter store, one word per entry
  // -----------------------------------------------------------------
  for (genvar g = 0; g < STORE_WORDS; g++) begin : g_store
    localparam logic [31:0] RST_VAL = (g == PARAM_SERIAL_ADDR) ? DEF_SERIAL_ADDR : 32'h0000_0000;
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        store_reg[g] <= RST_VAL;
      end else if (wr_en && wr_idx == 8'(g)) begin
        store_reg[g] <= wr_data;
      end
    end
  end

  // outputs; the serial address is only the low byte of parameter 66
  assign serial_addr = store_reg[PARAM_SERIAL_ADDR][7:0]; // R9
  assign rx_ready = (state_reg == S_RX);
  assign tx_valid = (state_reg == S_TX);
  assign tx_byte = tx_reg[cnt_reg];
  assign nvm_req = (state_reg == S_BOOT) || (state_reg == S_NVM);
  assign nvm_we = nvm_we_reg;
  assign nvm_addr = nvm_addr_reg;
  assign nvm_wdata = nvm_wdata_reg;
  assign accumulator = acc_reg;

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  sequence seq_exec(logic [7:0] ins);
    state_reg == S_EXEC && ex_ok && f_instr == ins;
  endsequence
  sequence seq_reply_ok;
    tx_reg[2] == STAT_OK && tx_reg[3] == $past(f_instr);
  endsequence

  AST_BANK_MAP: assert property (@(posedge clk) disable iff (!rst_n) // R1
    state_reg == S_EXEC && !ex_ok |=> state_reg == S_TX && tx_reg[2] == STAT_BAD_TYPE)
    else $error("bad bank or type not refused");
  AST_AUTO_SAVE: assert property (@(posedge clk) disable iff (!rst_n) // R2
    seq_exec(set_global_param_cmd) ##0 f_bank == BANK_MODULE
    |=> state_reg == S_NVM && nvm_we && nvm_req && nvm_wdata == $past(ex_val))
    else $error("bank 0 write not saved");
  AST_SET_WRITE: assert property (@(posedge clk) disable iff (!rst_n) // R3
    seq_exec(set_global_param_cmd) |=> store_reg[$past(ex_idx)] == $past(ex_val) ##0 seq_reply_ok)
    else $error("set value not written");
  AST_GET_ACC: assert property (@(posedge clk) disable iff (!rst_n) // R4
    seq_exec(get_global_param_cmd) ##0 standalone_mode |=> acc_reg == $past(rd_val))
    else $error("standalone read did not load accumulator");
  AST_GET_REPLY: assert property (@(posedge clk) disable iff (!rst_n) // R5
    seq_exec(get_global_param_cmd)
    |=> seq_reply_ok ##0 {tx_reg[4], tx_reg[5], tx_reg[6], tx_reg[7]} == $past(rd_val))
    else $error("read reply wrong");
  AST_DIRECT_ACC: assert property (@(posedge clk) disable iff (!rst_n) // R11
    state_reg == S_EXEC && !standalone_mode |=> $stable(acc_reg))
    else $error("direct read touched accumulator");
  AST_STORE: assert property (@(posedge clk) disable iff (!rst_n) // R6
    seq_exec(store_user_var_cmd) ##0 f_bank == BANK_UVAR
    |=> nvm_req && nvm_we && nvm_wdata == $past(rd_val) ##0 seq_reply_ok)
    else $error("store not issued");
  AST_BOOT: assert property (@(posedge clk) disable iff (!rst_n) // R7
    state_reg == S_INIT |=> state_reg == ($past(auto_restore_en) ? S_BOOT : S_RX))
    else $error("power-up restore choice wrong");
  AST_RESTORE: assert property (@(posedge clk) disable iff (!rst_n) // R8
    state_reg == S_NVM && !nvm_we && nvm_ack |=> store_reg[$past(idx_reg)] == $past(nvm_rdata))
    else $error("restore did not overwrite");
  AST_ADDR: assert property (@(posedge clk) disable iff (!rst_n) // R9
    seq_exec(set_global_param_cmd) ##0 f_bank == BANK_MODULE && f_type == PARAM_SERIAL_ADDR
    |=> serial_addr == $past(ex_val[7:0]))
    else $error("serial address not updated");
  AST_CSUM: assert property (@(posedge clk) disable iff (!rst_n) // R12
    tx_valid |-> tx_reg[8] == 8'(tx_reg[0] + tx_reg[1] + tx_reg[2] + tx_reg[3]
                                 + tx_reg[4] + tx_reg[5] + tx_reg[6] + tx_reg[7]))
    else $error("reply checksum wrong");
endmodule
`default_nettype wire

//--- pkg/gpc_pkg.sv
/*
  constants for the global parameter command handler: frame layout,
  instruction and status codes, bank numbers and storage map.
  assumes one synchronous clock domain and byte-wide frame streams.
*/
package gpc_pkg;
  // -----------------------------------------------------------------
  // frame layout
  // -----------------------------------------------------------------
  localparam int FRAME_LEN = 9;
  localparam logic [3:0] LAST_BYTE = 4'h8;
  localparam logic [3:0] FIRST_BYTE = 4'h0;
  localparam int F_ADDR = 0;
  localparam int F_INSTR = 1;
  localparam int F_TYPE = 2;
  localparam int F_BANK = 3;
  localparam int F_VAL3 = 4;
  // -----------------------------------------------------------------
  // instruction and status codes
  // -----------------------------------------------------------------
  localparam logic [7:0] set_global_param_cmd = 8'h09;
  localparam logic [7:0] get_global_param_cmd = 8'h0A;
  localparam logic [7:0] store_user_var_cmd = 8'h0B;
  localparam logic [7:0] restore_user_var_cmd = 8'h0C;
  localparam logic [7:0] STAT_OK = 8'h64;
  localparam logic [7:0] STAT_BAD_CSUM = 8'h01;
  localparam logic [7:0] STAT_BAD_CMD = 8'h02;
  localparam logic [7:0] STAT_BAD_TYPE = 8'h03;
  // -----------------------------------------------------------------
  // banks and storage map (one flat array of words)
  // -----------------------------------------------------------------
  localparam logic [7:0] BANK_MODULE = 8'h00;
  localparam logic [7:0] BANK_UVAR = 8'h02;
  localparam logic [7:0] BANK_IRQ = 8'h03;
  localparam logic [7:0] MOD_DEPTH = 8'h80;
  localparam logic [7:0] UVAR_DEPTH = 8'h40;
  localparam logic [7:0] IRQ_DEPTH = 8'h10;
  localparam logic [7:0] UVAR_BASE = 8'h80;
  localparam logic [7:0] IRQ_BASE = 8'hC0;
  localparam int STORE_WORDS = 208;
  localparam logic [7:0] PARAM_SERIAL_ADDR = 8'h42;
  localparam logic [31:0] DEF_SERIAL_ADDR = 32'h0000_0001;
  localparam logic [7:0] HOST_ADDR = 8'h02;
  localparam logic [5:0] UVAR_LAST = 6'h3F;
  typedef enum logic [2:0] {S_INIT, S_BOOT, S_RX, S_EXEC, S_NVM, S_TX} gpc_state_t;
endpackage

//--- tb/gpc_nvm_model.sv
/*
  behavioural non-volatile store for the command handler: one word per
  address, answers each request with a one-cycle ack after dly cycles.
  assumes requests held steady until ack, as the handler promises.
*/
`timescale 1ns/1ns
`default_nettype none
module gpc_nvm_model (
  input wire logic clk,
  input wire logic nvm_req,
  input wire logic nvm_we,
  input wire logic [9:0] nvm_addr,
  input wire logic [31:0] nvm_wdata,
  input wire logic [3:0] dly,
  output logic [31:0] nvm_rdata,
  output logic nvm_ack
);
  // -----------------------------------------------------------------
  // storage and answer logic
  // -----------------------------------------------------------------
  logic [31:0] mem [1024];
  logic [3:0] cnt;
  // user variable copies get a known pattern so a reload is visible
  initial begin
    nvm_ack = 1'b0;
    nvm_rdata = 32'h5A5A_5A5A;
    cnt = 4'h0;
    for (int i = 0; i < 1024; i++) begin
      mem[i] = (i >= 512 && i < 576) ? (32'hA500_0000 | 32'(i - 512)) : 32'h0000_0000;
    end
  end
  // read data is only valid with ack; otherwise it flips every cycle, except while a request waits for its ack
  always @(posedge clk) begin
    if (nvm_ack) begin
      nvm_ack <= 1'b0;
      nvm_rdata <= ~nvm_rdata;
    end else if (nvm_req && cnt >= dly) begin
      nvm_ack <= 1'b1;
      cnt <= 4'h0;
      if (nvm_we) begin
        mem[nvm_addr] <= nvm_wdata;
      end else begin
        nvm_rdata <= mem[nvm_addr];
      end
    end else if (nvm_req) begin
      cnt <= cnt + 4'h1;
    end else begin
      nvm_rdata <= ~nvm_rdata;
    end
  end
endmodule
`default_nettype wire

//--- tb/gpc_handler_tb.sv
/*
  self-checking bench for the command handler: sends frames, checks
  replies, accumulator, serial address and the store contents.
  assumes the store model in gpc_nvm_model and power-up reload on.
*/
`timescale 1ns/1ns
`default_nettype none
module gpc_handler_tb;
  import gpc_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, standalone_mode = 1'b0, auto_restore_en = 1'b1;
  logic rx_valid = 1'b0, tx_ready = 1'b1, stall = 1'b0;
  logic [7:0] rx_byte = 8'h00, me = 8'h01, old_me = 8'h01;
  logic [3:0] dly = 4'h0;
  logic rx_ready, tx_valid, nvm_req, nvm_we, nvm_ack;
  logic [7:0] tx_byte, serial_addr;
  logic [9:0] nvm_addr;
  logic [31:0] nvm_wdata, nvm_rdata, accumulator;
  int bad_count = 0, n_tests = 0;
  always #2 clk = ~clk;
  gpc_handler uut (.clk(clk), .nrst(nrst), .standalone_mode(standalone_mode),
    .auto_restore_en(auto_restore_en), .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready), .nvm_req(nvm_req), .nvm_we(nvm_we),
    .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata), .nvm_rdata(nvm_rdata), .nvm_ack(nvm_ack),
    .accumulator(accumulator), .serial_addr(serial_addr));
  gpc_nvm_model nvm (.clk(clk), .nvm_req(nvm_req), .nvm_we(nvm_we), .nvm_addr(nvm_addr),
    .nvm_wdata(nvm_wdata), .dly(dly), .nvm_rdata(nvm_rdata), .nvm_ack(nvm_ack));
  // -----------------------------------------------------------------
  // shared tasks
  // -----------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic timeout(input string what);
    bad_count++;
    $display("[FAIL] %0t no progress during %s", $time, what);
    complete_run();
  endtask
  // one full frame out, one reply in; frames to another address get none
  task automatic cmd(input logic [7:0] a, ins, typ, bank, input logic [31:0] v,
                     input logic [7:0] st, input logic [31:0] ev);
    logic [7:0] f [9];
    logic [7:0] r [9];
    logic [7:0] s;
    int k, n;
    f = '{a, ins, typ, bank, v[31:24], v[23:16], v[15:8], v[7:0], 8'h00};
    for (int i = 0; i < 8; i++) f[8] += f[i];
    for (int i = 0; i < 9; i++) begin
      k = 0;
      do begin
        @(negedge clk);
        k++;
      end while (rx_ready !== 1'b1 && k < 3000);
      if (k >= 3000) timeout("frame send");
      rx_valid = 1'b1;
      rx_byte = f[i];
    end
    @(negedge clk);
    rx_valid = 1'b0;
    if (a !== me) begin
      repeat (30) @(negedge clk) if (tx_valid !== 1'b0) check(tx_valid, 1'b0, "reply to other address");
      check(rx_ready, 1'b1, "ready after dropped frame");
      return;
    end
    n = 0;
    k = 0;
    while (n < 9 && k < 3000) begin
      @(negedge clk);
      k++;
      tx_ready = stall ? ~tx_ready : 1'b1;
      if (tx_valid === 1'b1 && tx_ready) begin
        r[n] = tx_byte;
        n++;
      end
    end
    if (n < 9) timeout("reply");
    s = 8'h00;
    for (int i = 0; i < 8; i++) s += r[i];
    check(r[0], HOST_ADDR, "reply host byte");
    check((r[1] === me) || (r[1] === old_me), 1'b1, "reply module address");
    check(r[2], st, "reply status");
    check(r[3], ins, "reply instruction");
    check({r[4], r[5], r[6], r[7]}, ev, "reply value msb first");
    check(r[8], s, "reply checksum");
  endtask
  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  task automatic t_boot(); // direct reads after power-up reload, junk in value field
    cmd(me, get_global_param_cmd, 8'h05, BANK_UVAR, 32'hFFFF_FFFF, STAT_OK, 32'hA500_0005);
    cmd(me, get_global_param_cmd, 8'h3F, BANK_UVAR, 32'h1234_5678, STAT_OK, 32'hA500_003F);
    check(accumulator, 32'h0000_0000, "accumulator in direct mode");
  endtask
  task automatic t_banks(); // same type in each bank must land in separate places
    logic [7:0] bl [3] = '{BANK_MODULE, BANK_UVAR, BANK_IRQ};
    for (int i = 0; i < 3; i++) begin
      cmd(me, set_global_param_cmd, 8'h03, bl[i], 32'h1234_5600 | i, STAT_OK, 32'h0);
    end
    for (int i = 0; i < 3; i++) begin
      cmd(me, get_global_param_cmd, 8'h03, bl[i], 32'h0, STAT_OK, 32'h1234_5600 | i);
    end
    check(nvm.mem[10'h003], 32'h1234_5600, "bank 0 auto save");
    check(nvm.mem[10'h203], 32'hA500_0003, "user variable not auto saved");
  endtask
  task automatic t_addr(); // new address takes effect; old one is ignored
    cmd(me, set_global_param_cmd, PARAM_SERIAL_ADDR, BANK_MODULE, 32'h3, STAT_OK, 32'h0);
    me = 8'h03;
    check(serial_addr, 8'h03, "serial address output");
    cmd(8'h01, get_global_param_cmd, PARAM_SERIAL_ADDR, BANK_MODULE, 32'h0, STAT_OK, 32'h0);
    old_me = me;
    cmd(me, get_global_param_cmd, PARAM_SERIAL_ADDR, BANK_MODULE, 32'h0, STAT_OK, 32'h3);
  endtask
  task automatic t_store(); // slow store and a stalling host
    dly = 4'h5;
    stall = 1'b1;
    cmd(me, set_global_param_cmd, 8'h07, BANK_UVAR, 32'hCAFE_0007, STAT_OK, 32'h0);
    cmd(me, store_user_var_cmd, 8'h07, BANK_UVAR, 32'h0, STAT_OK, 32'h0);
    check(nvm.mem[10'h207], 32'hCAFE_0007, "stored user variable");
    cmd(me, set_global_param_cmd, 8'h07, BANK_UVAR, 32'h0BAD_0000, STAT_OK, 32'h0);
    cmd(me, restore_user_var_cmd, 8'h07, BANK_UVAR, 32'h0, STAT_OK, 32'h0);
    cmd(me, get_global_param_cmd, 8'h07, BANK_UVAR, 32'h0, STAT_OK, 32'hCAFE_0007);
    cmd(me, store_user_var_cmd, 8'h07, BANK_MODULE, 32'h0, STAT_BAD_CMD, 32'h0);
    stall = 1'b0;
    dly = 4'h0;
  endtask
  task automatic t_standalone(); // reads load the accumulator only in standalone
    standalone_mode = 1'b1;
    cmd(me, get_global_param_cmd, 8'h07, BANK_UVAR, 32'h0, STAT_OK, 32'hCAFE_0007);
    check(accumulator, 32'hCAFE_0007, "accumulator in standalone");
    standalone_mode = 1'b0;
    cmd(me, get_global_param_cmd, 8'h05, BANK_UVAR, 32'h0, STAT_OK, 32'hA500_0005);
    check(accumulator, 32'hCAFE_0007, "accumulator kept in direct");
  endtask
  // mid-run reset with reload off: user variables stay at zero until restored
  task automatic t_reset();
    @(negedge clk);
    auto_restore_en = 1'b0;
    nrst = 1'b0;
    repeat (8) @(negedge clk);
    check(rx_ready, 1'b0, "ready held low in reset");
    check(serial_addr, 8'h01, "serial address back to default");
    nrst = 1'b1;
    me = 8'h01;
    old_me = 8'h01;
    cmd(me, get_global_param_cmd, 8'h05, BANK_UVAR, 32'h0, STAT_OK, 32'h0);
    cmd(me, restore_user_var_cmd, 8'h07, BANK_UVAR, 32'h0, STAT_OK, 32'h0);
    cmd(me, get_global_param_cmd, 8'h07, BANK_UVAR, 32'h0, STAT_OK, 32'hCAFE_0007);
  endtask
  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    t_boot();
    t_banks();
    t_addr();
    t_store();
    t_standalone();
    t_reset();
    complete_run();
  end
endmodule
`default_nettype wire
